// ===== include/ssw_pkg.sv
// Constants and carrier types for the supply supervisor reset block.
// Assumes a 20 MHz system clock; all timing derives from it.
package ssw_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RST_HOLD_TIME_MS = 200;
    localparam int unsigned WDOG_PERIOD_MS = 1600;
    localparam int unsigned MR_NOISE_NS = 100;
    localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned WDOG_PERIOD_CYCLES = WDOG_PERIOD_MS * (CLK_HZ / 1000);
    // Noise window rounded up, plus one so a pulse of that width is rejected
    localparam int unsigned MR_FILT_CYCLES =
        (MR_NOISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned MR_FILT_W = 4;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic supply_low;
        logic manual_rst_in_n;
        logic wdog_strobe_in;
        logic wdog_disable;
    } ssw_src_s;

    // Idle pad levels in src packing; manual reset input rests high
    localparam logic [3:0] SRC_IDLE = 4'h4;

    typedef struct packed {
        logic rst_n;
        logic rst;
    } ssw_rst_s;

    typedef enum logic [1:0] {
        SSW_SRC_NONE,
        SSW_SRC_SUPPLY,
        SSW_SRC_MANUAL,
        SSW_SRC_WDOG
    } ssw_cause_e;

endpackage

// ===== design/ssw_supervisor.sv
// Reset generator: supply trip, manual reset and watchdog into one reset pair.
// Assumes all source inputs are asynchronous pads; one 20 MHz clock.
// Assumes pad logic flags a floating strobe on its own disable input.
//
// What this block does
// - Manual input low asserts resets; hold them rst_hold_time after it rises.
// - Supply below trip level asserts both resets at once, no timer.
// - After supply recovers, keep resets asserted for the full hold time.
// - Hold time is fixed, 200 ms typical, same for every source.
// - Active-high reset is always the inverse of active-low reset.
// - Strobe unchanged longer than wdog_period makes the watchdog expire.
// - Watchdog timer clears on every strobe edge and while reset asserted.
// - Floating strobe disables the watchdog so it never resets.
// - Watchdog expiry asserts resets, holds them the hold time, then releases.
// - Watchdog stays cleared during any reset, restarts when reset releases.
// - Manual reset low pulses of about 100 ns are ignored as noise.
`timescale 1ns/1ps

module ssw_supervisor #(
    parameter int unsigned HOLD_CYCLES = ssw_pkg::RST_HOLD_CYCLES,
    parameter int unsigned WDOG_CYCLES = ssw_pkg::WDOG_PERIOD_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire ssw_pkg::ssw_src_s src_i,
    output ssw_pkg::ssw_rst_s rst_o,
    output ssw_pkg::ssw_cause_e cause_o
);
    import ssw_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Three stages per pad; a change counts once stages two and three agree
    logic [3:0] raw;
    logic [3:0] stable;
    logic [3:0] next_stable;

    assign raw = src_i;

    for (genvar g = 0; g < 4; g++) begin : g_sync
        logic [2:0] stage;
        logic [2:0] next_stage;
        logic level;
        logic next_level;

        always_comb begin
            next_stage = {stage[1:0], raw[g]};
            next_level = level;
            // Stage one may still be settling, so it never decides alone
            if (stage[1] == stage[2]) begin
                next_level = stage[2];
            end
        end

        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                stage <= {3{SRC_IDLE[g]}};
                level <= SRC_IDLE[g];
            end else begin
                stage <= next_stage;
                level <= next_level;
            end
        end

        assign stable[g] = level;
        assign next_stable[g] = next_level;
    end

    ssw_src_s src_s;
    ssw_src_s next_src_s;
    assign src_s = stable;
    assign next_src_s = next_stable;

    // ****************************************
    // Manual reset noise filter
    // ****************************************
    // Short lows are rejected; costs a few cycles of assert latency
    logic [MR_FILT_W-1:0] mr_cnt;
    logic [MR_FILT_W-1:0] next_mr_cnt;
    logic mr_active;
    logic next_mr_active;

    always_comb begin
        next_mr_cnt = '0;
        next_mr_active = 1'b0;
        if (!src_s.manual_rst_in_n) begin
            next_mr_cnt = mr_cnt;
            next_mr_active = mr_active;
            if (mr_cnt == MR_FILT_W'(MR_FILT_CYCLES)) begin
                next_mr_active = 1'b1;
            end else begin
                next_mr_cnt = mr_cnt + MR_FILT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mr_cnt <= '0;
            mr_active <= 1'b0;
        end else begin
            mr_cnt <= next_mr_cnt;
            mr_active <= next_mr_active;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] next_wd_cnt;
    logic wd_prev;
    logic next_wd_prev;
    logic wd_expire;
    logic wd_edge;
    logic rst_asserted;

    assign wd_edge = src_s.wdog_strobe_in ^ wd_prev;

    always_comb begin
        next_wd_cnt = wd_cnt + CNT_W'(1);
        wd_expire = 1'b0;
        // Edges taken from the synchronised level, so idle gives no false edge
        next_wd_prev = src_s.wdog_strobe_in;
        if (rst_asserted || wd_edge || src_s.wdog_disable) begin
            next_wd_cnt = '0;
        end else if (wd_cnt >= CNT_W'(WDOG_CYCLES - 1)) begin
            wd_expire = 1'b1;
            next_wd_cnt = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wd_cnt <= '0;
            wd_prev <= 1'b0;
        end else begin
            wd_cnt <= next_wd_cnt;
            wd_prev <= next_wd_prev;
        end
    end

    // ****************************************
    // Reset hold timer
    // ****************************************
    // Power-up counts as a supply trip, so reset holds after release
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] next_hold_cnt;
    logic rst_q;
    logic next_rst_q;
    ssw_cause_e cause;
    ssw_cause_e next_cause;
    logic level_src;

    assign level_src = src_s.supply_low || mr_active;

    always_comb begin
        next_hold_cnt = hold_cnt;
        next_rst_q = rst_q;
        next_cause = cause;
        if (level_src) begin
            next_rst_q = 1'b1;
            next_hold_cnt = '0;
            next_cause = src_s.supply_low ? SSW_SRC_SUPPLY : SSW_SRC_MANUAL;
        end else if (wd_expire) begin
            // Expiry yields to a level source, which restarts the hold anyway
            next_rst_q = 1'b1;
            next_hold_cnt = '0;
            next_cause = SSW_SRC_WDOG;
        end else if (rst_q) begin
            if (hold_cnt >= CNT_W'(HOLD_CYCLES - 1)) begin
                next_rst_q = 1'b0;
                next_hold_cnt = '0;
            end else begin
                next_hold_cnt = hold_cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_cnt <= '0;
            rst_q <= 1'b1;
            cause <= SSW_SRC_SUPPLY;
        end else begin
            hold_cnt <= next_hold_cnt;
            rst_q <= next_rst_q;
            cause <= next_cause;
        end
    end

    // ****************************************
    // Reset outputs
    // ****************************************
    // Supply trip skips the hold timer so it acts at once
    // Registered from next values: no glitch reaches the pins, no added lag
    logic rst_out;
    logic next_rst_out;

    always_comb begin
        next_rst_out = next_rst_q || next_src_s.supply_low;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_out <= 1'b1;
        end else begin
            rst_out <= next_rst_out;
        end
    end

    assign rst_asserted = rst_out;
    assign rst_o.rst = rst_out;
    assign rst_o.rst_n = ~rst_out;
    assign cause_o = cause;

endmodule // ssw_supervisor

// ===== sim/ssw_sup_assertions.sv
// Checker for the supervisor reset pair.
// Bound to ssw_supervisor; sees only its ports.
`timescale 1ns/1ps
module ssw_sup_chk #(
    parameter int HOLD_CYCLES = 50,
    parameter int WDOG_CYCLES = 200
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire ssw_pkg::ssw_src_s src_i,
    input wire ssw_pkg::ssw_rst_s rst_o,
    input wire ssw_pkg::ssw_cause_e cause_o
);
    import ssw_pkg::*;
    // ****
    // Reference counters
    // ****
    logic [31:0] wd_cnt;
    logic [31:0] quiet;
    logic [31:0] hi_cnt;
    logic strobe_q;
    logic wd_clr;
    assign wd_clr = rst_o.rst || src_i.wdog_disable || strobe_q != src_i.wdog_strobe_in;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wd_cnt <= '0;
            quiet <= '0;
            hi_cnt <= '0;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= src_i.wdog_strobe_in;
            quiet <= (src_i.supply_low || !src_i.manual_rst_in_n) ? '0 : quiet + 1;
            hi_cnt <= rst_o.rst ? hi_cnt + 1 : '0;
            wd_cnt <= wd_clr ? '0 : wd_cnt + 1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ****
    // Properties
    // ****
    out_inverse_a: assert property (rst_o.rst == !rst_o.rst_n)
        else $error("reset pair not inverse");
    supply_fast_a: assert property (src_i.supply_low [*6] |-> rst_o.rst)
        else $error("supply trip slow");
    manual_on_a: assert property (!src_i.manual_rst_in_n [*8] ##1
        !src_i.manual_rst_in_n [*4] |-> rst_o.rst) else $error("manual reset missed");
    noise_skip_a: assert property (src_i.manual_rst_in_n && !rst_o.rst && quiet > 16
        && src_i.wdog_disable ##1 !src_i.manual_rst_in_n ##1 src_i.manual_rst_in_n [*8]
        |-> !rst_o.rst) else $error("noise pulse reset");
    hold_time_a: assert property ($fell(rst_o.rst) |-> hi_cnt >= HOLD_CYCLES - 1)
        else $error("reset hold short");
    hold_end_a: assert property (quiet == HOLD_CYCLES + 10 && src_i.wdog_disable
        |-> !rst_o.rst) else $error("reset hold long");
    wdog_late_a: assert property (!rst_o.rst |-> wd_cnt <= WDOG_CYCLES + 10)
        else $error("watchdog missed");
    wdog_early_a: assert property ($rose(rst_o.rst) && quiet > 16
        |-> wd_cnt >= WDOG_CYCLES - 8) else $error("watchdog early");
    wdog_off_a: assert property (src_i.wdog_disable [*8] ##0 quiet > 16
        |-> !$rose(rst_o.rst)) else $error("disabled watchdog fired");
    wdog_cause_a: assert property ($rose(rst_o.rst) && quiet > 16
        |-> ##[0:2] cause_o == SSW_SRC_WDOG) else $error("wrong cause");
endmodule // ssw_sup_chk

bind ssw_supervisor ssw_sup_chk #(.HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .src_i(src_i), .rst_o(rst_o),
    .cause_o(cause_o));

// ===== sim/ssw_host_model.sv
// Processor model: strobes the watchdog while out of reset.
// Toggles every period_i cycles; stall_i freezes the strobe.
`timescale 1ns/1ps
module ssw_host_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic [7:0] period_i,
    output logic strobe_o
);
    logic [7:0] cnt = '0;
    initial strobe_o = 1'b0;
    // Firmware only kicks once out of reset
    always @(posedge sys_clk_i) begin
        if (rst_i || stall_i) begin
            cnt <= '0;
        end else if (cnt + 8'h01 >= period_i) begin
            cnt <= '0;
            strobe_o <= !strobe_o;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // ssw_host_model

// ===== sim/tb_supply_supervisor_watchdog_reset.sv
// Self-checking bench for the supervisor reset block.
// Short counts: hold 50, watchdog 200 cycles.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module tb_supply_supervisor_watchdog_reset;
    import ssw_pkg::*;
    localparam int HOLD = 50;
    localparam int WDOG = 200;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sup = 1'b0, mr_n = 1'b1, dis = 1'b1, stall = 1'b0, strobe;
    logic [7:0] period = 8'h20;
    logic [31:0] lfsr = 32'h470CA5E7;
    ssw_src_s src;
    ssw_rst_s rst;
    ssw_cause_e cause;
    int num_errors = 0, check_count = 0, cyc = 0, n;
    assign src = {sup, mr_n, strobe, dis};
    ssw_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) DUT (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .src_i(src), .rst_o(rst), .cause_o(cause));
    ssw_host_model u_host (.sys_clk_i(sys_clk_i), .rst_i(rst.rst), .stall_i(stall),
        .period_i(period), .strobe_o(strobe));
    initial forever #25 sys_clk_i = !sys_clk_i;
    function automatic logic [31:0] nx(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Release lands a few sync cycles late
    function automatic bit near(int c, int b);
        return c >= b && c <= b + 10;
    endfunction
    task automatic wt(input logic v, output int c);
        for (c = 0; c < 1000 && rst.rst !== v; c++) begin
            @(posedge sys_clk_i);
            #1;
        end
        if (c >= 1000) begin
            num_errors++;
            $display("unexpected at %0t: reset level wait ran out", $time);
        end
    endtask
    task automatic pulse(input bit man, input int len, input ssw_cause_e exp);
        @(posedge sys_clk_i);
        if (man) mr_n <= 1'b0;
        else sup <= 1'b1;
        repeat (len) @(posedge sys_clk_i);
        #1;
        `CHK(rst.rst, 1'b1)
        `CHK(rst.rst_n, 1'b0)
        `CHK(cause, exp)
        @(posedge sys_clk_i);
        mr_n <= 1'b1;
        sup <= 1'b0;
        wt(1'b0, n);
        `CHK(near(n, HOLD), 1'b1)
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        `CHK(cause, SSW_SRC_SUPPLY)
        reset_n_i <= 1'b1;
        wt(1'b0, n);
        `CHK(near(n, HOLD), 1'b1)
        for (int i = 0; i < 8; i++) begin
            lfsr = nx(lfsr);
            pulse(i[0], i[0] ? 12 + lfsr[4:0] : 6, i[0] ? SSW_SRC_MANUAL : SSW_SRC_SUPPLY);
        end
        @(posedge sys_clk_i);
        mr_n <= 1'b0;
        @(posedge sys_clk_i);
        mr_n <= 1'b1;
        dis <= 1'b0;
        repeat (30) @(posedge sys_clk_i);
        #1;
        `CHK(rst.rst, 1'b0)
        @(posedge sys_clk_i);
        mr_n <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        mr_n <= 1'b1;
        repeat (30) @(posedge sys_clk_i);
        #1;
        `CHK(rst.rst, 1'b0)
        for (int i = 0; i < 6; i++) begin
            lfsr = nx(lfsr);
            @(posedge sys_clk_i);
            period <= 8'd20 + {1'b0, lfsr[6:0]};
            repeat (300) @(posedge sys_clk_i);
        end
        #1;
        `CHK(rst.rst, 1'b0)
        stall <= 1'b1;
        wt(1'b1, n);
        wt(1'b0, n);
        wt(1'b1, n);
        `CHK(near(n, WDOG), 1'b1)
        `CHK(cause, SSW_SRC_WDOG)
        wt(1'b0, n);
        `CHK(near(n, HOLD), 1'b1)
        repeat (100) @(posedge sys_clk_i);
        pulse(1'b1, 12, SSW_SRC_MANUAL);
        wt(1'b1, n);
        `CHK(near(n, WDOG), 1'b1)
        wt(1'b0, n);
        @(posedge sys_clk_i);
        dis <= 1'b1;
        repeat (600) @(posedge sys_clk_i);
        #1;
        `CHK(rst.rst, 1'b0)
        test_done();
    end
endmodule // tb_supply_supervisor_watchdog_reset
